// File: core/sapa_consts.svh
`ifndef SAPA_CONSTS_SVH
`define SAPA_CONSTS_SVH
// Overview of operation
// - i2s master drives sck/ws; slave takes them in
// - i2s channel word is 16 bits, left first
// - i2s msb one bit after ws change, falling
// - left while ws low, right while high
// - launch i2s bits on fall, capture on rise
// - one shared engine, i2s or pcm, never both
// - pcm master makes clock/sync; slave takes them
// - up to three channels in sixteen slots
// - slot count follows the selected rate code
// - tx and rx of a channel share slot
// - data output released in unowned slots
// - release after falling edge in last bit
// - short and long sync in both roles
// - short sync: one-bit pulse before slot zero
// - slave sees sync on fall, data next rise
// - long sync: three bits from slot zero start
// - narrowband uses 13 of 16 bits, placeable
// - spare bits ignored in, filled out as set
// - reset format: 13-bit, left, msb first
// - burst mode fixes the bit clock half period at 3
// - every port setting is host programmable

`define SAPA_OFF_CTRL 8'h00
`define SAPA_OFF_CFG 8'h04
`define SAPA_OFF_FMT 8'h08
`define SAPA_OFF_CHAN 8'h0c
`define SAPA_OFF_TX0 8'h10
`define SAPA_OFF_TX1 8'h14
`define SAPA_OFF_TX2 8'h18
`define SAPA_OFF_RX0 8'h20
`define SAPA_OFF_RX1 8'h24
`define SAPA_OFF_RX2 8'h28
`define SAPA_OFF_STAT 8'h2c

`define SAPA_CTRL_EN 0
`define SAPA_CTRL_PCM 1
`define SAPA_CTRL_MASTER 2
`define SAPA_CTRL_LONG 3
`define SAPA_CTRL_BURST 4
`define SAPA_FMT_N13 0
`define SAPA_FMT_LSBF 1
`define SAPA_FMT_RJ 2

`define SAPA_CTRL_RST 5'h00
`define SAPA_CFG_RST 16'h0400
`define SAPA_FMT_RST 8'h01
`define SAPA_CHAN_RST 16'h0000

`define SAPA_BURST_HALF 8'h03
`define SAPA_I2S_LAST 8'h1f
`define SAPA_LONG_SYNC_BITS 8'h03
`define SAPA_MAX_RATE 3'h4
`define SAPA_NCH 3
`endif

// File: core/sapa_pkg.sv
package sapa_pkg;
  typedef enum logic [1:0] {
    SAPA_FILL_ZERO  = 2'b00,
    SAPA_FILL_ONE   = 2'b01,
    SAPA_FILL_SIGN  = 2'b10,
    SAPA_FILL_CONST = 2'b11
  } sapa_fill_type;
endpackage

// File: core/sapa_sync.sv
`timescale 1ns/100ps
module sapa_sync #(
  parameter int W = 3
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta;
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          meta   <= 1'b0;
          o_q[g] <= 1'b0;
        end else begin
          meta   <= i_d[g];
          o_q[g] <= meta;
        end
      end
    end
  endgenerate
endmodule

// File: core/sapa_clkgen.sv
`timescale 1ns/100ps
module sapa_clkgen (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_en,
  input  wire logic       i_master,
  input  wire logic [7:0] i_half,
  input  wire logic       i_sck_s,
  output logic            o_sck,
  output logic            o_rise,
  output logic            o_fall
);
  logic [7:0] cnt;
  logic       sck_prev;
  logic       tick;

  assign tick = i_en && i_master && (cnt >= i_half - 8'h01);

  always_ff @(posedge i_clk) begin
    if (i_rst || !i_en || !i_master) begin
      cnt   <= 8'h00;
      o_sck <= 1'b0;
    end else if (tick) begin
      cnt   <= 8'h00;
      o_sck <= ~o_sck;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= i_sck_s;
    end
  end

  // edges of own divider in master, of synced pin in slave
  always_comb begin
    if (i_master) begin
      o_rise = tick && !o_sck;
      o_fall = tick && o_sck;
    end else begin
      o_rise = i_en && i_sck_s && !sck_prev;
      o_fall = i_en && !i_sck_s && sck_prev;
    end
  end
endmodule

// File: core/sapa_top.sv
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "sapa_consts.svh"
module sapa_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_sck,
  output logic             o_sck,
  output logic             o_sck_oe_n,
  input  wire logic        i_fs,
  output logic             o_fs,
  output logic             o_fs_oe_n,
  input  wire logic        i_sd,
  output logic             o_sd,
  output logic             o_sd_oe_n
);
  logic [4:0]  ctrl;
  logic [15:0] cfg;
  logic [7:0]  fmt;
  logic [15:0] chan;
  logic [15:0] tx_word [0:2];
  logic [15:0] rx_word [0:2];
  logic [7:0]  frame_cnt;

  logic        act_en;
  logic        act_pcm;
  logic        act_master;
  logic        act_long;
  logic        act_burst;
  logic [2:0]  act_rate;
  logic [7:0]  act_half;
  logic [7:0]  act_fmt;
  logic [15:0] act_chan;

  logic [2:0]  pin_s;
  logic        sck_s;
  logic        fs_s;
  logic        sd_s;
  logic        edge_rise;
  logic        edge_fall;
  logic        gen_sck;
  logic        launch;
  logic        capture;
  logic [7:0]  half_eff;

  logic [4:0]  nslots;
  logic [8:0]  frame_bits;
  logic [8:0]  frame_bits_m1;
  logic [7:0]  last_pos;
  logic [7:0]  pos;
  logic [7:0]  next_pos;
  logic        frame_start;
  logic        fs_prev;
  logic        realign;
  logic [7:0]  align_pos;

  logic [2:0]  hit_next;
  logic [2:0]  hit_cur;
  logic        own_next;
  logic        own_cur;
  logic [1:0]  ch_next;
  logic [1:0]  ch_cur;
  logic [15:0] tx_src;
  logic [15:0] tx_sh;
  logic [15:0] rx_sh;
  logic [15:0] rx_full;

  logic        apb_wr;
  logic        mapped;
  logic [31:0] rd_mux;

  // host port
  assign apb_wr   = i_psel && i_penable && i_pwrite && mapped;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;

  always_comb begin
    case (i_paddr)
      `SAPA_OFF_CTRL, `SAPA_OFF_CFG, `SAPA_OFF_FMT, `SAPA_OFF_CHAN,
      `SAPA_OFF_TX0, `SAPA_OFF_TX1, `SAPA_OFF_TX2,
      `SAPA_OFF_RX0, `SAPA_OFF_RX1, `SAPA_OFF_RX2,
      `SAPA_OFF_STAT: mapped = 1'b1;
      default:        mapped = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl       <= `SAPA_CTRL_RST;
      cfg        <= `SAPA_CFG_RST;
      fmt        <= `SAPA_FMT_RST;
      chan       <= `SAPA_CHAN_RST;
      tx_word[0] <= 16'h0000;
      tx_word[1] <= 16'h0000;
      tx_word[2] <= 16'h0000;
    end else if (apb_wr) begin
      case (i_paddr)
        `SAPA_OFF_CTRL: ctrl       <= i_pwdata[4:0];
        `SAPA_OFF_CFG:  cfg        <= i_pwdata[15:0];
        `SAPA_OFF_FMT:  fmt        <= i_pwdata[7:0];
        `SAPA_OFF_CHAN: chan       <= i_pwdata[15:0];
        `SAPA_OFF_TX0:  tx_word[0] <= i_pwdata[15:0];
        `SAPA_OFF_TX1:  tx_word[1] <= i_pwdata[15:0];
        `SAPA_OFF_TX2:  tx_word[2] <= i_pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (i_paddr)
      `SAPA_OFF_CTRL: rd_mux = {27'h0000000, ctrl};
      `SAPA_OFF_CFG:  rd_mux = {16'h0000, cfg};
      `SAPA_OFF_FMT:  rd_mux = {24'h000000, fmt};
      `SAPA_OFF_CHAN: rd_mux = {16'h0000, chan};
      `SAPA_OFF_TX0:  rd_mux = {16'h0000, tx_word[0]};
      `SAPA_OFF_TX1:  rd_mux = {16'h0000, tx_word[1]};
      `SAPA_OFF_TX2:  rd_mux = {16'h0000, tx_word[2]};
      `SAPA_OFF_RX0:  rd_mux = {16'h0000, rx_word[0]};
      `SAPA_OFF_RX1:  rd_mux = {16'h0000, rx_word[1]};
      `SAPA_OFF_RX2:  rd_mux = {16'h0000, rx_word[2]};
      `SAPA_OFF_STAT: rd_mux = {8'h00, pos, frame_cnt,
                                5'h00, act_master, act_pcm, act_en};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  // read data captured in the setup phase, valid in access
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h00000000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= rd_mux;
    end
  end

  // working copy: follows host while idle or on disable, else at frame edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      act_en     <= 1'b0;
      act_pcm    <= 1'b0;
      act_master <= 1'b0;
      act_long   <= 1'b0;
      act_burst  <= 1'b0;
      act_rate   <= 3'(`SAPA_CFG_RST);
      act_half   <= 8'(`SAPA_CFG_RST >> 8);
      act_fmt    <= `SAPA_FMT_RST;
      act_chan   <= `SAPA_CHAN_RST;
    end else if (!act_en || !ctrl[`SAPA_CTRL_EN] || frame_start) begin
      act_en     <= ctrl[`SAPA_CTRL_EN];
      act_pcm    <= ctrl[`SAPA_CTRL_PCM];
      act_master <= ctrl[`SAPA_CTRL_MASTER];
      act_long   <= ctrl[`SAPA_CTRL_LONG];
      act_burst  <= ctrl[`SAPA_CTRL_BURST];
      act_rate   <= cfg[2:0];
      act_half   <= cfg[15:8];
      act_fmt    <= fmt;
      act_chan   <= chan;
    end
  end

  sapa_sync #(
    .W (3)
  ) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_sd, i_fs, i_sck}),
    .o_q   (pin_s)
  );
  assign sck_s = pin_s[0];
  assign fs_s  = pin_s[1];
  assign sd_s  = pin_s[2];

  // burst forces a divider half period of 3
  always_comb begin
    if (act_burst) begin
      half_eff = `SAPA_BURST_HALF;
    end else if (act_half == 8'h00) begin
      half_eff = 8'h01;
    end else begin
      half_eff = act_half;
    end
  end

  sapa_clkgen u_clkgen (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_en     (act_en),
    .i_master (act_master),
    .i_half   (half_eff),
    .i_sck_s  (sck_s),
    .o_sck    (gen_sck),
    .o_rise   (edge_rise),
    .o_fall   (edge_fall)
  );

  // i2s launches on fall; pcm launches on rise
  assign launch  = act_pcm ? edge_rise : edge_fall;
  assign capture = act_pcm ? edge_fall : edge_rise;

  // rate code 0..4 gives 1,2,4,8,16 slots
  always_comb begin
    if (act_rate > `SAPA_MAX_RATE) begin
      nslots = 5'h10;
    end else begin
      nslots = 5'(5'h01 << act_rate);
    end
  end
  assign frame_bits    = {nslots, 4'h0};
  assign frame_bits_m1 = frame_bits - 9'h001;
  assign last_pos = act_pcm ? frame_bits_m1[7:0] : `SAPA_I2S_LAST;
  assign next_pos = (pos == last_pos) ? 8'h00 : pos + 8'h01;
  assign frame_start = act_en && launch && (next_pos == 8'h00);

  // slave alignment from ws change or sync pulse
  always_comb begin
    realign   = 1'b0;
    align_pos = pos;
    if (!act_pcm) begin
      realign   = fs_s != fs_prev;
      align_pos = fs_s ? 8'h0f : 8'h1f;
    end else if (fs_s && !fs_prev) begin
      realign   = 1'b1;
      align_pos = act_long ? 8'h00 : last_pos;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fs_prev <= 1'b0;
    end else if (capture) begin
      fs_prev <= fs_s;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pos <= 8'h00;
    end else if (!act_en) begin
      pos <= last_pos;
    end else if (launch) begin
      pos <= next_pos;
    end else if (capture && !act_master && realign) begin
      pos <= align_pos;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      frame_cnt <= 8'h00;
    end else if (frame_start) begin
      frame_cnt <= frame_cnt + 8'h01;
    end
  end

  // slot ownership for the next and the current bit
  genvar c;
  generate
    for (c = 0; c < `SAPA_NCH; c++) begin : g_ch
      assign hit_next[c] = act_chan[c]
        && (act_chan[4*c+7:4*c+4] == next_pos[7:4])
        && ({1'b0, next_pos[7:4]} < nslots);
      assign hit_cur[c] = act_chan[c]
        && (act_chan[4*c+7:4*c+4] == pos[7:4])
        && ({1'b0, pos[7:4]} < nslots);
    end
  endgenerate

  always_comb begin
    own_next = |hit_next;
    own_cur  = |hit_cur;
    ch_next  = hit_next[0] ? 2'd0 : (hit_next[1] ? 2'd1 : 2'd2);
    ch_cur   = hit_cur[0] ? 2'd0 : (hit_cur[1] ? 2'd1 : 2'd2);
  end

  function automatic logic [15:0] sapa_rev(input logic [15:0] w);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = w[15-i];
    end
    return r;
  endfunction

  function automatic logic [15:0] sapa_fmt_tx(input logic [15:0] w,
                                              input logic [7:0]  f);
    logic [2:0]  fill;
    logic [15:0] t;
    case (sapa_pkg::sapa_fill_type'(f[4:3]))
      sapa_pkg::SAPA_FILL_ZERO: fill = 3'h0;
      sapa_pkg::SAPA_FILL_ONE:  fill = 3'h7;
      sapa_pkg::SAPA_FILL_SIGN: fill = {3{w[12]}};
      default:                  fill = f[7:5];
    endcase
    if (f[`SAPA_FMT_N13]) begin
      t = f[`SAPA_FMT_RJ] ? {fill, w[12:0]} : {w[12:0], fill};
    end else begin
      t = w;
    end
    return f[`SAPA_FMT_LSBF] ? sapa_rev(t) : t;
  endfunction

  function automatic logic [15:0] sapa_fmt_rx(input logic [15:0] w,
                                              input logic [7:0]  f);
    logic [15:0] t;
    logic [12:0] s;
    t = f[`SAPA_FMT_LSBF] ? sapa_rev(w) : w;
    s = f[`SAPA_FMT_RJ] ? t[12:0] : t[15:3];
    return f[`SAPA_FMT_N13] ? {{3{s[12]}}, s} : t;
  endfunction

  // word source: i2s by ws half, pcm by slot owner
  always_comb begin
    if (!act_pcm) begin
      tx_src = tx_word[{1'b0, next_pos[4]}];
    end else begin
      tx_src = sapa_fmt_tx(tx_word[ch_next], act_fmt);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_sh <= 16'h0000;
      o_sd  <= 1'b0;
    end else if (!act_en) begin
      o_sd <= 1'b0;
    end else if (launch) begin
      if (next_pos[3:0] == 4'h0) begin
        tx_sh <= tx_src;
        o_sd  <= tx_src[15];
      end else begin
        o_sd  <= tx_sh[4'hf - next_pos[3:0]];
      end
    end
  end

  // pcm output driven only inside owned slots
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sd_oe_n <= 1'b0;
    end else if (!act_pcm) begin
      o_sd_oe_n <= 1'b0;
    end else if (!act_en) begin
      o_sd_oe_n <= 1'b1;
    end else if (launch) begin
      o_sd_oe_n <= !own_next;
    end else if (!own_cur) begin
      o_sd_oe_n <= 1'b1;
    end else if (edge_fall && pos[3:0] == 4'hf) begin
      o_sd_oe_n <= 1'b1;
    end
  end

  assign rx_full = {rx_sh[14:0], sd_s};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_sh <= 16'h0000;
    end else if (act_en && capture) begin
      rx_sh <= rx_full;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_word[0] <= 16'h0000;
      rx_word[1] <= 16'h0000;
      rx_word[2] <= 16'h0000;
    end else if (act_en && capture && pos[3:0] == 4'hf) begin
      if (!act_pcm) begin
        rx_word[{1'b0, pos[4]}] <= rx_full;
      end else if (own_cur) begin
        rx_word[ch_cur] <= sapa_fmt_rx(rx_full, act_fmt);
      end
    end
  end

  // frame sync or word select, master only
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fs <= 1'b0;
    end else if (!act_en || !act_master) begin
      o_fs <= 1'b0;
    end else if (launch) begin
      if (!act_pcm) begin
        if (next_pos == 8'h0f) begin
          o_fs <= 1'b1;
        end else if (next_pos == 8'h1f) begin
          o_fs <= 1'b0;
        end
      end else if (act_long) begin
        o_fs <= next_pos < `SAPA_LONG_SYNC_BITS;
      end else begin
        o_fs <= next_pos == last_pos;
      end
    end
  end

  assign o_sck      = gen_sck;
  assign o_sck_oe_n = !act_master;
  assign o_fs_oe_n  = !act_master;
endmodule

// File: dv/sapa_top_assertions.sv
`timescale 1ns/100ps
module sapa_top_assertions (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_sck,
  input wire logic        o_sck_oe_n,
  input wire logic        o_fs,
  input wire logic        o_fs_oe_n,
  input wire logic        o_sd,
  input wire logic        o_sd_oe_n
);
  logic [4:0] ctrl_q;
  logic [7:0] half_q;
  logic [8:0] settle;
  logic [7:0] hc;
  logic [7:0] fc;
  logic [7:0] hexp;
  logic       wr;
  logic       mapped;
  logic       steady;
  logic       mst;
  assign wr     = i_psel && i_penable && i_pwrite;
  assign mapped = i_paddr[1:0] == 2'h0 && i_paddr <= 8'h2c
                  && i_paddr != 8'h1c;
  assign steady = settle == 9'h1ff;
  assign mst    = steady && ctrl_q[0] && ctrl_q[2];
  assign hexp   = ctrl_q[4] ? 8'h03 : (half_q == 8'h00 ? 8'h01 : half_q);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q <= 5'h00;
      half_q <= 8'h04;
    end else if (wr && i_paddr == 8'h00)
      ctrl_q <= i_pwdata[4:0];
    else if (wr && i_paddr == 8'h04)
      half_q <= i_pwdata[15:8];
  end

  // quiet for longer than a frame since the last ctrl or cfg write
  always_ff @(posedge i_clk) begin
    if (i_rst || (wr && i_paddr[7:3] == 5'h00))
      settle <= 9'h000;
    else if (!steady)
      settle <= settle + 9'h001;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hc <= 8'h00;
      fc <= 8'h00;
    end else begin
      hc <= $changed(o_sck) ? 8'h01 : hc + {7'h00, hc != 8'hff};
      fc <= !o_fs ? 8'h00 : fc + {7'h00, fc != 8'hff};
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  property p_ready_now;
    i_psel |-> o_pready;
  endproperty
  a_ready_now: assert property (p_ready_now)
    else $error("pready low in a transfer");
  property p_unmapped_err;
    i_psel && i_penable && !mapped |-> o_pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("no error on unmapped address");
  property p_mapped_ok;
    i_psel && i_penable && mapped |-> !o_pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("error on mapped address");
  property p_role_pins;
    steady && ctrl_q[0] |-> o_sck_oe_n == !ctrl_q[2]
                            && o_fs_oe_n == !ctrl_q[2];
  endproperty
  a_role_pins: assert property (p_role_pins)
    else $error("clock or sync pin direction wrong for role");
  property p_i2s_sd_driven;
    steady && !ctrl_q[1] |-> !o_sd_oe_n;
  endproperty
  a_i2s_sd_driven: assert property (p_i2s_sd_driven)
    else $error("serial data not driven in i2s mode");
  property p_sck_half;
    mst && $changed(o_sck) |-> hc == hexp;
  endproperty
  a_sck_half: assert property (p_sck_half)
    else $error("bit clock half period wrong");
  property p_i2s_fall_launch;
    mst && !ctrl_q[1] && ($changed(o_sd) || $changed(o_fs)) |-> !o_sck;
  endproperty
  a_i2s_fall_launch: assert property (p_i2s_fall_launch)
    else $error("i2s data or ws moved while clock high");
  property p_pcm_rise_launch;
    mst && ctrl_q[1] && !o_sd_oe_n && $changed(o_sd) |-> o_sck;
  endproperty
  a_pcm_rise_launch: assert property (p_pcm_rise_launch)
    else $error("pcm data moved while clock low");
  property p_release_fall;
    mst && ctrl_q[1] && $rose(o_sd_oe_n) |-> !o_sck;
  endproperty
  a_release_fall: assert property (p_release_fall)
    else $error("pcm data released outside the falling edge");
  property p_frame_width;
    mst && $fell(o_fs) |-> fc == (!ctrl_q[1] ? 8'h20 :
                                  (ctrl_q[3] ? 8'h06 : 8'h02)) * hexp;
  endproperty
  a_frame_width: assert property (p_frame_width)
    else $error("sync or ws high time wrong");
endmodule

bind sapa_top sapa_top_assertions i_chk (.i_clk, .i_rst, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .o_sck,
  .o_sck_oe_n, .o_fs, .o_fs_oe_n, .o_sd, .o_sd_oe_n);

// File: dv/sapa_partner.sv
`timescale 1ns/100ps
module sapa_partner (
  input  wire logic        i_gen,
  input  wire logic        i_pcm,
  input  wire logic        i_long,
  input  wire logic [15:0] i_word,
  input  wire logic        i_sck,
  input  wire logic        i_fs,
  input  wire logic        i_sd,
  output logic             o_sck,
  output logic             o_fs,
  output logic             o_sd,
  output logic      [15:0] o_capl,
  output logic      [15:0] o_capr
);
  logic [15:0] sh;
  logic [4:0]  cn;
  logic [3:0]  gbit;
  logic        ws_q;
  // pcm clock master, 16-bit frame, clock still when idle
  initial begin
    {o_sck, o_fs, o_sd, ws_q} = 4'h0;
    {o_capl, o_capr, sh} = 48'h0;
    cn = 5'h10;
    gbit = 4'hf;
    #37;
    forever begin
      if (i_gen) begin
        gbit = gbit + 4'h1;
        o_fs = i_long ? gbit < 4'h3 : gbit == 4'hf;
        o_sck = 1'b1;
        #400;
        o_sck = 1'b0;
        #400;
      end else begin
        o_sck = 1'b0;
        o_fs = 1'b0;
        #100;
      end
    end
  end
  always @(posedge i_sck) begin
    if (!i_pcm) begin
      ws_q <= i_fs;
      sh <= {sh[14:0], i_sd};
      if (i_fs != ws_q && !ws_q)
        o_capl <= {sh[14:0], i_sd};
      if (i_fs != ws_q && ws_q)
        o_capr <= {sh[14:0], i_sd};
    end else if (i_gen)
      o_sd <= i_word[~gbit];
    else
      o_sd <= cn < 5'h10 ? i_word[4'hf - cn[3:0]] : ~o_sd;
  end
  always @(negedge i_sck) begin
    if (!i_pcm)
      o_sd <= ~o_sd;
    else begin
      if (cn < 5'h10)
        sh <= {sh[14:0], i_sd};
      if (cn == 5'h0f)
        o_capl <= {sh[14:0], i_sd};
      cn <= i_fs && !i_long ? 5'h00 : cn + {4'h0, cn < 5'h10};
    end
  end
endmodule

// File: dv/shared_i2s_pcm_audio_port_tb.sv
`timescale 1ns/100ps
module shared_i2s_pcm_audio_port_tb;
  localparam logic [7:0]  fm_tab [8] = '{8'h01, 8'h09, 8'h11, 8'h11,
                                         8'hb9, 8'h05, 8'h03, 8'h00};
  localparam logic [15:0] tx_tab [8] = '{16'h1a5c, 16'h1a5c, 16'h0a5c,
    16'h1a5c, 16'h1a5c, 16'h1a5c, 16'h1a5c, 16'h8a5c};
  localparam logic [15:0] ex_tab [8] = '{16'hd2e0, 16'hd2e7, 16'h52e0,
    16'hd2e7, 16'hd2e5, 16'h1a5c, 16'h074b, 16'h8a5c};
  logic        i_clk, i_rst, i_psel, i_penable, i_pwrite, i_sd, er;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, o_sck, o_sck_oe_n, o_fs, o_fs_oe_n;
  logic        o_sd, o_sd_oe_n, p_gen, p_pcm, p_long, p_sck, p_fs;
  logic [15:0] p_word, capl, capr;
  int          miscompares, tests_run;
  wire         i_sck = o_sck_oe_n ? p_sck : o_sck;
  wire         i_fs  = o_fs_oe_n ? p_fs : o_fs;
  // pulled up when released; flight time keeps the fall sample clean
  wire #20     sd_w  = o_sd_oe_n ? 1'b1 : o_sd;

  sapa_top i_dut (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_sck, .o_sck,
    .o_sck_oe_n, .i_fs, .o_fs, .o_fs_oe_n, .i_sd, .o_sd, .o_sd_oe_n);
  sapa_partner i_far (.i_gen(p_gen), .i_pcm(p_pcm), .i_long(p_long),
    .i_word(p_word), .i_sck, .i_fs, .i_sd(sd_w), .o_sck(p_sck),
    .o_fs(p_fs), .o_sd(i_sd), .o_capl(capl), .o_capr(capr));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic expire;
    $display("Error wait expired");
    miscompares++;
    test_done;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    for (n = 0; n < 20 && o_pready !== 1'b1; n++)
      @(posedge i_clk);
    if (n == 20)
      expire;
    rd = o_prdata;
    er = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wait_cap(input logic right, input logic [15:0] e);
    int n;
    for (n = 0; n < 4000 && (right ? capr : capl) !== e; n++)
      @(posedge i_clk);
    if (n == 4000)
      expire;
    chk({16'h0, right ? capr : capl}, {16'h0, e}, "frame word");
  endtask

  task automatic t_regs;
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000_0400, "cfg reset");
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0000_0001, "fmt reset");
    apb(1'b1, 8'h0c, 32'hffff_ffff);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0000_ffff, "chan readback");
    apb(1'b0, 8'h1c, 32'h0);
    chk({rd[30:0], er}, 32'h0000_0001, "unmapped read");
  endtask

  task automatic t_i2s_master;
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 8'h10, 32'h0000_a5c3 + k);
      apb(1'b1, 8'h14, 32'h0000_3c5a + k);
      apb(1'b1, 8'h00, k ? 32'h15 : 32'h05);
      wait_cap(1'b1, 16'h3c5a + k);
      wait_cap(1'b0, 16'ha5c3 + k);
      repeat (600) @(posedge i_clk); // settled run for the pin checks
      chk({31'h0, o_sck_oe_n}, 32'h0, "master clock driven");
    end
    apb(1'b1, 8'h00, 32'h0);
  endtask

  task automatic t_pcm_master;
    p_pcm  <= 1'b1;
    p_word <= 16'hc3a5;
    apb(1'b1, 8'h04, 32'h0000_0401);
    apb(1'b1, 8'h0c, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h08, {24'h0, fm_tab[i]});
      apb(1'b1, 8'h10, {16'h0, tx_tab[i]});
      if (i == 0)
        apb(1'b1, 8'h00, 32'h07);
      wait_cap(1'b0, ex_tab[i]);
      if (i == 1) begin
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0000_f874, "rx narrowband");
        apb(1'b0, 8'h2c, 32'h0);
        chk({29'h0, rd[2:0]}, 32'h7, "active state");
      end
    end
    apb(1'b1, 8'h00, 32'h0);
  endtask

  task automatic t_pcm_slave_long;
    int n;
    apb(1'b1, 8'h04, 32'h0000_0400);
    apb(1'b1, 8'h08, 32'h0000_0001);
    p_long <= 1'b1;
    p_gen  <= 1'b1;
    p_word <= 16'h5a3c;
    apb(1'b1, 8'h00, 32'h0b);
    for (n = 0; n < 200 && rd !== 32'h0000_0b47; n++)
      apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0000_0b47, "slave rx word");
    chk({30'h0, o_sck_oe_n, o_fs_oe_n}, 32'h3, "slave pins in");
    p_gen <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
  endtask

  initial begin
    {i_rst, i_psel, i_penable, i_pwrite} = 4'h8;
    {i_paddr, i_pwdata} = 40'h0;
    {p_gen, p_pcm, p_long, p_word} = 19'h0;
    {miscompares, tests_run} = 64'h0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs;
    t_i2s_master;
    t_pcm_master;
    t_pcm_slave_long;
    test_done;
  end

  initial begin
    #9_000_000;
    expire;
  end
endmodule
